// [src/dpm_host.sv]
// Left-port controller that drives the dual-port mailbox/token memory
`timescale 1ns/1ps
`default_nettype none
// What the document says
// R1: Device holds a shared 36-bit array; host reaches it by address and data.
// R2: Host reads of data written by far side may be stale until flowthrough.
// R3: Host reads memory with chip select and output enable both active.
// R4: Host reads a token with token select active instead of chip select.
// R5: Mailboxes sit at the top two addresses; ours is the lower one.
// R6: Writing the far mailbox interrupts the far port.
// R7: Reading our own mailbox clears our interrupt.
// R8: Reading the far mailbox leaves its interrupt alone.
// R9: Busy active blocks mailbox interrupt set and clear for that port.
// R10: Device arbitrates matching addresses and asserts busy to the loser.
// R11: Busy rises from address match or from chip select onto a match.
// R12: Role pin high makes busy an output; low makes it an input.
// R13: In slave mode host waits for busy to settle before writing.
// R14: Device holds eight token latches apart from the array.
// R15: Host takes a token by writing 0 then reading back; 0 means owned.
// R16: Host deselects for the update pulse between token write and read.
// R17: Token select is latch select; host keeps chip select off meanwhile.
// R18: Device also allows token access with chip select and all lanes high.
// R19: Address bits 0-2 pick the latch; other address bits are ignored.
// R20: Token write uses only data bit 0.
// R21: Owner writing 1 frees the latch when no request is pending.
// R22: A pending far request gets the token when the owner releases it.
// R23: Simultaneous requests give the token to exactly one port.
// R24: In slave mode an active busy input holds off the memory write.
module dpm_host
    import dpm_pkg::*;
(
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // Command port
    input  wire logic [7:0]          cmd_addr,
    input  wire logic [31:0]         cmd_wdata,
    input  wire logic                cmd_wr,
    input  wire logic                cmd_rd,
    output logic [31:0]              cmd_rdata,
    // Device port pins
    output logic [ADDR_W-1:0]        mem_addr,
    output logic                     chip_sel_n,
    output logic                     token_select_n,
    output logic                     rw_n,
    output logic                     out_en_n,
    output logic [3:0]               byte_lane_select_n,
    output logic [DATA_W-1:0]        data_o,
    output logic                     data_oe_n,
    input  wire logic [DATA_W-1:0]   data_i,
    input  wire logic                busy_n,
    input  wire logic                irq_n,
    output logic                     role_master
);

    // ****************************************
    // Pin input synchronisers
    // ****************************************
    logic [DATA_W+1:0] pins_sync;
    logic [DATA_W-1:0] data_s;
    logic              busy_s;
    logic              irq_s;

    dpm_sync2 #(.W(DATA_W + 2)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d_in     ({busy_n, irq_n, data_i}),
        .q_out    (pins_sync)
    );
    assign busy_s = ~pins_sync[DATA_W+1];
    assign irq_s  = ~pins_sync[DATA_W];
    assign data_s = pins_sync[DATA_W-1:0];

    // ****************************************
    // State
    // ****************************************
    dpm_state_e        st_reg, st_next;
    logic [CNT_W-1:0]  cnt_reg, cnt_next;
    logic [1:0]        op_reg, op_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic              done_reg, done_next;
    logic              owned_reg, owned_next;
    logic              master_reg, master_next;
    logic [31:0]       rd_reg, rd_next;
    logic [ADDR_W-1:0] pa_reg, pa_next;
    logic              cs_n_reg, cs_n_next;
    logic              sem_n_reg, sem_n_next;
    logic              rw_reg, rw_next;
    logic              oe_n_reg, oe_n_next;
    logic [DATA_W-1:0] do_reg, do_next;
    logic              doe_n_reg, doe_n_next;

    // Cycle count for a timing constant, at least one
    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = (n < 1) ? CNT_W'(1) : CNT_W'(n);
    endfunction

    // Token ops target a latch index; only the low three address bits count
    function automatic logic is_token(input logic [1:0] op);
        is_token = (op == OP_TOKEN_TAKE) || (op == OP_TOKEN_FREE);
    endfunction

    // Command intake, register file and sequencer
    always_comb
    begin
        st_next    = st_reg;
        cnt_next   = cnt_reg;
        op_next    = op_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        done_next  = done_reg;
        owned_next = owned_reg;
        master_next = master_reg;
        pa_next    = pa_reg;
        cs_n_next  = cs_n_reg;
        sem_n_next = sem_n_reg;
        rw_next    = rw_reg;
        oe_n_next  = oe_n_reg;
        do_next    = do_reg;
        doe_n_next = doe_n_reg;
        rd_next    = 32'h0000_0000;

        // Register reads, one cycle later
        if (cmd_rd)
        begin
            case (cmd_addr)
                REG_ADDR:   rd_next = 32'(addr_reg);
                REG_WDATA:  rd_next = wdata_reg[31:0];
                REG_RDATA:  rd_next = rdata_reg[31:0];
                REG_STATUS: rd_next = {27'h0, (st_reg == DPM_SETTLE), irq_s, owned_reg,
                                       done_reg, (st_reg != DPM_IDLE)};
                REG_CONFIG: rd_next = {31'h0, ~master_reg};
                default:    rd_next = 32'h0000_0000;
            endcase
        end

        // Register writes; parameters ignored while a command runs
        if (cmd_wr && st_reg == DPM_IDLE)
        begin
            case (cmd_addr)
                REG_ADDR:   addr_next  = cmd_wdata[ADDR_W-1:0];
                REG_WDATA:  wdata_next = {4'h0, cmd_wdata};
                REG_CONFIG: master_next = ~cmd_wdata[CFG_SLAVE_BIT];
                REG_CTRL:
                begin
                    if (cmd_wdata[CTRL_GO_BIT])
                    begin
                        op_next   = cmd_wdata[CTRL_OP_LSB +: 2];
                        done_next = 1'b0;
                        st_next   = DPM_SETUP;
                    end
                end
                default: ;
            endcase
        end

        case (st_reg)
            DPM_IDLE: ;
            DPM_SETUP:
            begin
                cnt_next = cyc(ACCESS_CYC);
                if (is_token(op_reg))
                begin
                    pa_next    = {{(ADDR_W-TOKEN_AW){1'b0}}, addr_reg[TOKEN_AW-1:0]}; // [R19]
                    sem_n_next = 1'b0;                      // [R4] [R17]
                    cs_n_next  = 1'b1;                      // [R17]
                    rw_next    = 1'b0;
                    do_next    = {{(DATA_W-1){1'b0}}, (op_reg == OP_TOKEN_FREE)}; // [R15] [R20]
                    doe_n_next = 1'b0;
                    st_next    = DPM_STROBE;
                end
                else
                begin
                    pa_next   = addr_reg;                  // [R1] [R5]
                    cs_n_next = 1'b0;
                    if (op_reg == OP_WRITE)
                    begin
                        do_next    = wdata_reg;
                        doe_n_next = 1'b0;
                        cnt_next   = cyc(SETTLE_CYC);
                        st_next    = master_reg ? DPM_STROBE : DPM_SETTLE; // [R13]
                        if (master_reg)
                        begin
                            rw_next  = 1'b0;
                            cnt_next = cyc(WRITE_CYC);
                        end
                    end
                    else
                    begin
                        oe_n_next = 1'b0;                  // [R3]
                        cnt_next  = cyc(ACCESS_CYC + 2);   // Access plus synchroniser
                        st_next   = DPM_STROBE;
                    end
                end
            end
            DPM_SETTLE:
            begin
                // Slave write waits out busy settle and any active busy
                if (cnt_reg > CNT_W'(1))
                    cnt_next = cnt_reg - CNT_W'(1);
                else if (!busy_s)                           // [R24] [R12]
                begin
                    rw_next  = 1'b0;
                    cnt_next = cyc(WRITE_CYC);
                    st_next  = DPM_STROBE;
                end
            end
            DPM_STROBE:
            begin
                if (cnt_reg > CNT_W'(1))
                    cnt_next = cnt_reg - CNT_W'(1);
                else if (op_reg == OP_READ)
                begin
                    rdata_next = data_s;                   // [R2] [R7] [R8]
                    oe_n_next  = 1'b1;
                    cs_n_next  = 1'b1;
                    st_next    = DPM_END;
                end
                else
                begin
                    rw_next    = 1'b1;                     // Write ends on strobe rise
                    sem_n_next = 1'b1;                     // [R16]
                    cs_n_next  = 1'b1;
                    doe_n_next = 1'b1;
                    // [R6] [R9] [R21] [R22]
                    if (op_reg == OP_TOKEN_TAKE)
                    begin
                        cnt_next = cyc(UPDATE_CYC);
                        st_next  = DPM_GAP;
                    end
                    else
                        st_next = DPM_END;
                end
            end
            DPM_GAP:
            begin
                if (cnt_reg > CNT_W'(1))
                    cnt_next = cnt_reg - CNT_W'(1);
                else
                begin
                    sem_n_next = 1'b0;                     // [R4] [R16]
                    oe_n_next  = 1'b0;
                    cnt_next   = cyc(ACCESS_CYC + 2);
                    st_next    = DPM_TREAD;
                end
            end
            DPM_TREAD:
            begin
                if (cnt_reg > CNT_W'(1))
                    cnt_next = cnt_reg - CNT_W'(1);
                else
                begin
                    owned_next = ~data_s[0];               // [R15] [R23]
                    rdata_next = data_s;
                    sem_n_next = 1'b1;
                    oe_n_next  = 1'b1;
                    st_next    = DPM_END;
                end
            end
            DPM_END:
            begin
                done_next = 1'b1;
                st_next   = DPM_IDLE;
            end
            default: st_next = DPM_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg    <= DPM_IDLE;
            cnt_reg   <= '0;
            op_reg    <= OP_READ;
            addr_reg  <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            done_reg  <= 1'b0;
            owned_reg <= 1'b0;
            master_reg <= ~CONFIG_RESET[CFG_SLAVE_BIT];
            rd_reg    <= 32'h0000_0000;
            pa_reg    <= '0;
            cs_n_reg  <= 1'b1;
            sem_n_reg <= 1'b1;
            rw_reg    <= 1'b1;
            oe_n_reg  <= 1'b1;
            do_reg    <= '0;
            doe_n_reg <= 1'b1;
        end
        else
        begin
            st_reg    <= st_next;
            cnt_reg   <= cnt_next;
            op_reg    <= op_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            done_reg  <= done_next;
            owned_reg <= owned_next;
            master_reg <= master_next;
            rd_reg    <= rd_next;
            pa_reg    <= pa_next;
            cs_n_reg  <= cs_n_next;
            sem_n_reg <= sem_n_next;
            rw_reg    <= rw_next;
            oe_n_reg  <= oe_n_next;
            do_reg    <= do_next;
            doe_n_reg <= doe_n_next;
        end
    end

    // Outputs straight from flip-flops
    assign cmd_rdata          = rd_reg;
    assign mem_addr           = pa_reg;
    assign chip_sel_n         = cs_n_reg;
    assign token_select_n     = sem_n_reg;
    assign rw_n               = rw_reg;
    assign out_en_n           = oe_n_reg;
    assign byte_lane_select_n = {4{cs_n_reg}};   // All lanes with the word access
    assign data_o             = do_reg;
    assign data_oe_n          = doe_n_reg;
    assign role_master        = master_reg;      // [R12]

endmodule
`default_nettype wire

// [src/dpm_pkg.sv]
// Package: constants for the dual-port mailbox/token memory port controller
package dpm_pkg;

    // ****************************************
    // Device geometry
    // ****************************************
    localparam int ADDR_W     = 15;            // Address pins, large variant
    localparam int DATA_W     = 36;            // Word width of the array
    localparam int TOKEN_AW   = 3;             // Address bits that pick a token latch
    localparam logic [14:0] MBOX_SELF_ADDR  = 15'h7ffe; // Mailbox that interrupts us
    localparam logic [14:0] MBOX_OTHER_ADDR = 15'h7fff; // Mailbox of the far port

    // ****************************************
    // Timing at 50 MHz core clock
    // ****************************************
    localparam int CLK_PERIOD_NS        = 20;
    localparam int ACCESS_NS            = 20;  // Read access, largest speed grade
    localparam int WRITE_PULSE_NS       = 20;  // Write strobe width
    localparam int TOKEN_UPDATE_PULSE_NS = 10; // Deselect between token write and read
    localparam int BUSY_SETTLE_NS       = 20;  // Busy settle before a slave write
    localparam int ACCESS_CYC  = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC   = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UPDATE_CYC  =
        (TOKEN_UPDATE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC  = (BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W       = 4;

    // ****************************************
    // Command register map (byte addresses)
    // ****************************************
    localparam logic [7:0] REG_CTRL   = 8'h00; // W: [0] go, [2:1] op
    localparam logic [7:0] REG_ADDR   = 8'h04; // RW: word address / token index
    localparam logic [7:0] REG_WDATA  = 8'h08; // RW: write data
    localparam logic [7:0] REG_RDATA  = 8'h0c; // R: last read data
    localparam logic [7:0] REG_STATUS = 8'h10; // R: status bits
    localparam logic [7:0] REG_CONFIG = 8'h14; // RW: [0] slave mode

    localparam int CTRL_GO_BIT   = 0;
    localparam int CTRL_OP_LSB   = 1;
    localparam int ST_BUSY_BIT   = 0;          // Command in progress
    localparam int ST_DONE_BIT   = 1;          // Sticky done
    localparam int ST_OWNED_BIT  = 2;          // Last token attempt won
    localparam int ST_IRQ_BIT    = 3;          // Mailbox interrupt level
    localparam int ST_WAIT_BIT   = 4;          // Waiting on busy input
    localparam int CFG_SLAVE_BIT = 0;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

    // Operations
    localparam logic [1:0] OP_READ        = 2'h0;
    localparam logic [1:0] OP_WRITE       = 2'h1;
    localparam logic [1:0] OP_TOKEN_TAKE  = 2'h2; // Write 0, pulse off, read back
    localparam logic [1:0] OP_TOKEN_FREE  = 2'h3; // Write 1

    typedef enum logic [2:0] {
        DPM_IDLE, DPM_SETUP, DPM_SETTLE, DPM_STROBE, DPM_GAP, DPM_TREAD, DPM_END
    } dpm_state_e;

endpackage

// [src/dpm_sync2.sv]
// Two-flop synchroniser for the device's asynchronous data and status pins
`timescale 1ns/1ps
`default_nettype none
module dpm_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] d_in,
    output logic [W-1:0]      q_out
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    // Next values: first stage samples, second stage copies it
    always_comb
    begin
        meta_next = d_in;
        q_next    = meta_reg;
    end

    // Registers, idle high as the pins are active low
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= '1;
            q_reg    <= '1;
        end
        else
        begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q_out = q_reg;

endmodule
`default_nettype wire

// [test/dpm_dev_model.sv]
// Behavioural model of the dual-port device seen from its left port
`timescale 1ns/1ps
`default_nettype none
module dpm_dev_model
    import dpm_pkg::*;
(
    // Clock used only to sample the host strobes
    input  wire logic              core_clk,
    // Left port pins
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic              chip_sel_n,
    input  wire logic              token_select_n,
    input  wire logic              rw_n,
    input  wire logic              out_en_n,
    input  wire logic [DATA_W-1:0] data_o,
    input  wire logic              busy_n,  // Arbitration outcome
    input  wire logic              role_master,
    output logic [DATA_W-1:0]      data_i,
    output logic                   irq_n
);
    // ****************************************
    // Storage, token latches and flags
    // ****************************************
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [1:0]        owner [8];                // 0 free, 1 left, 2 right
    logic [1:0]        pend [8];                 // Waiting request per side
    logic              irq_far_n = 1'b1;
    logic [DATA_W-1:0] last = '0;
    logic              drive;

    // Latches start free and our interrupt idle
    initial
    begin
        irq_n = 1'b1;
        foreach (owner[i])
        begin
            owner[i] = 2'h0;
            pend[i] = 2'h0;
        end
    end

    // Token update from either side; only data bit 0 counts
    task automatic tok_wr(input int i, input int side, input logic v);
        logic [1:0] me;
        me = 2'(side + 1);
        if (!v && owner[i] == 2'h0)
            owner[i] = me;
        else if (!v && owner[i] != me)
            pend[i][side] = 1'b1;
        else if (v && owner[i] == me)
        begin
            owner[i] = pend[i][1-side] ? 2'(2 - side) : 2'h0;
            pend[i][1-side] = 1'b0;
        end
        else if (v)
            pend[i][side] = 1'b0;
    endtask

    // Far side writes a word; our mailbox raises our interrupt
    task automatic right_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        mem[a] = d;
        if (a == MBOX_SELF_ADDR)
            irq_n = 1'b0;
    endtask

    // Read path; a released bus shows the inverse of the last value
    always @*
    begin
        drive = rw_n && !out_en_n && (!chip_sel_n || !token_select_n);
        data_i = ~last;
        if (drive && !token_select_n)
            data_i = {35'h0, owner[mem_addr[2:0]] != 2'h1};
        else if (drive && mem.exists(mem_addr))
            data_i = mem[mem_addr];
    end

    // Write path, mailbox flags and held-off slave writes
    always @(posedge core_clk)
    begin
        if (drive)
            last <= data_i;
        if (!rw_n && !token_select_n)
            tok_wr(int'(mem_addr[2:0]), 0, data_o[0]);
        if (!rw_n && !chip_sel_n && (role_master || busy_n))
        begin
            mem[mem_addr] = data_o;
            if (mem_addr == MBOX_OTHER_ADDR && busy_n)
                irq_far_n = 1'b0;
        end
        if (drive && !chip_sel_n && busy_n && mem_addr == MBOX_SELF_ADDR)
            irq_n = 1'b1;
    end
endmodule
`default_nettype wire

// [test/dpm_host_sva.sv]
// Checker for the pin sequences and command read data of the host port controller
`timescale 1ns/1ps
`default_nettype none
module dpm_host_sva (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Command port
    input  wire logic        cmd_rd,
    input  wire logic [31:0] cmd_rdata,
    // Device pins
    input  wire logic        chip_sel_n,
    input  wire logic        token_select_n,
    input  wire logic        rw_n,
    input  wire logic        out_en_n,
    input  wire logic [3:0]  byte_lane_select_n,
    input  wire logic        data_oe_n,
    input  wire logic        busy_n,
    input  wire logic        role_master
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ****************************************
    // Pin and command read data assertions
    // ****************************************
    one_select_a: assert property (chip_sel_n || token_select_n)
        else $error("memory and token selects both active");
    lanes_follow_a: assert property (byte_lane_select_n == {4{chip_sel_n}})
        else $error("byte lanes differ from chip select");
    read_enable_a: assert property (!out_en_n |-> rw_n && !(chip_sel_n && token_select_n))
        else $error("output enable without a read select");
    mem_read_a: assert property ($fell(chip_sel_n) && rw_n && data_oe_n
        |-> (!chip_sel_n && !out_en_n)[*3] ##1 chip_sel_n) else $error("memory read shape");
    token_read_a: assert property ($fell(token_select_n) && rw_n
        |-> (!token_select_n && !out_en_n)[*3] ##1 token_select_n) else $error("token read shape");
    token_gap_a: assert property ($fell(token_select_n) && !rw_n
        |=> token_select_n && rw_n && out_en_n) else $error("no update pulse after token write");
    master_write_a: assert property ($fell(rw_n) && !chip_sel_n && role_master
        |-> !data_oe_n ##1 (rw_n && chip_sel_n && data_oe_n)) else $error("write shape");
    write_drive_a: assert property (!rw_n |-> !data_oe_n)
        else $error("write strobe without data driven");
    slave_hold_a: assert property ((!role_master && !busy_n)[*5] |-> rw_n || chip_sel_n)
        else $error("slave write while busy held");
    rdata_idle_a: assert property (!$past(cmd_rd) |-> cmd_rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule

bind dpm_host dpm_host_sva u_sva (
    .core_clk(core_clk), .rst(rst), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
    .chip_sel_n(chip_sel_n), .token_select_n(token_select_n), .rw_n(rw_n),
    .out_en_n(out_en_n), .byte_lane_select_n(byte_lane_select_n),
    .data_oe_n(data_oe_n), .busy_n(busy_n), .role_master(role_master));
`default_nettype wire

// [test/dpm_host_tb.sv]
// Self-checking testbench for the host port controller
`timescale 1ns/1ps
`default_nettype none
module dpm_host_tb;
    import dpm_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] cmd_addr = '0;
    logic [31:0] cmd_wdata = '0;
    logic cmd_wr = 1'b0, cmd_rd = 1'b0;
    logic busy_n = 1'b1;
    logic [31:0] cmd_rdata, seed = 32'h497661da, s, a, d;
    logic [ADDR_W-1:0] mem_addr;
    logic chip_sel_n, token_select_n, rw_n, out_en_n, data_oe_n, irq_n, role_master;
    logic [3:0] byte_lane_select_n;
    logic [DATA_W-1:0] data_o, data_i;
    int n_errors = 0, n_checks = 0, cycles = 0;

    dpm_host dut (.core_clk(core_clk), .rst(rst), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .mem_addr(mem_addr),
        .chip_sel_n(chip_sel_n), .token_select_n(token_select_n), .rw_n(rw_n),
        .out_en_n(out_en_n), .byte_lane_select_n(byte_lane_select_n), .data_o(data_o),
        .data_oe_n(data_oe_n), .data_i(data_i), .busy_n(busy_n), .irq_n(irq_n),
        .role_master(role_master));
    dpm_dev_model dev (.core_clk(core_clk), .mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
        .token_select_n(token_select_n), .rw_n(rw_n), .out_en_n(out_en_n), .data_o(data_o),
        .busy_n(busy_n), .role_master(role_master), .data_i(data_i), .irq_n(irq_n));

    // Clock and hang guard
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Word as stored: software data in the low 32 bits, top bits zero
    function automatic logic [DATA_W-1:0] exp_word(input logic [31:0] v);
        return {4'h0, v};
    endfunction

    task automatic chk(input string name, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic reg_wr(input logic [7:0] ra, input logic [31:0] v);
        @(posedge core_clk);
        cmd_addr <= ra;
        cmd_wdata <= v;
        cmd_wr <= 1'b1;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] ra, output logic [31:0] v);
        @(posedge core_clk);
        cmd_addr <= ra;
        cmd_rd <= 1'b1;
        @(posedge core_clk);
        cmd_rd <= 1'b0;
        #1 v = cmd_rdata;
    endtask

    task automatic start_op(input logic [1:0] op, input logic [31:0] ad, input logic [31:0] v);
        reg_wr(REG_ADDR, ad);
        reg_wr(REG_WDATA, v);
        reg_wr(REG_CTRL, {29'h0, op, 1'b1});
    endtask

    task automatic wait_done(output logic [31:0] st);
        st = '0;
        for (int k = 0; k < 60 && st[ST_DONE_BIT] !== 1'b1; k++)
            reg_rd(REG_STATUS, st);
        chk("done", 1, st[ST_DONE_BIT]);
    endtask

    task automatic run_op(input logic [1:0] op, input logic [31:0] ad, input logic [31:0] v);
        start_op(op, ad, v);
        wait_done(s);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1 chk("pins idle", 6'h3f,
            {role_master, chip_sel_n, token_select_n, rw_n, out_en_n, data_oe_n});
        reg_rd(REG_CONFIG, s);
        chk("config", 0, s);
        reg_rd(8'h18, s);
        chk("unmapped", 0, s);
        $display("reset test done");
        for (int i = 0; i < 8; i++)
        begin
            a = xs() & 32'h3fff;
            d = (i == 0) ? 32'hffff_ffff : xs();
            run_op(OP_WRITE, a, d);
            chk("array", exp_word(d), dev.mem[a[14:0]]);
            run_op(OP_READ, a, 32'h0);
            reg_rd(REG_RDATA, s);
            chk("read back", d, s);
        end
        $display("array test done");
        d = xs();
        dev.right_write(MBOX_SELF_ADDR, exp_word(d));
        run_op(OP_READ, MBOX_OTHER_ADDR, 32'h0);
        chk("irq set", 1, s[ST_IRQ_BIT]);
        run_op(OP_WRITE, MBOX_OTHER_ADDR, xs());
        chk("far irq", 0, dev.irq_far_n);
        busy_n <= 1'b0;
        run_op(OP_READ, MBOX_SELF_ADDR, 32'h0);
        busy_n <= 1'b1;
        chk("irq kept", 1, s[ST_IRQ_BIT]);
        run_op(OP_READ, MBOX_SELF_ADDR, 32'h0);
        reg_rd(REG_RDATA, s);
        chk("mailbox data", d, s);
        reg_rd(REG_STATUS, s);
        chk("irq cleared", 0, s[ST_IRQ_BIT]);
        $display("mailbox test done");
        for (int i = 0; i < 8; i++)
        begin
            a = (xs() & ~32'h7) | 32'(i);
            run_op(OP_TOKEN_TAKE, a, 32'h0);
            chk("take free", 1, s[ST_OWNED_BIT]);
            dev.tok_wr(i, 1, 1'b0);
            run_op(OP_TOKEN_FREE, a, 32'h0);
            chk("hand over", 2, dev.owner[i]);
            run_op(OP_TOKEN_TAKE, a, 32'h0);
            chk("take held", 0, s[ST_OWNED_BIT]);
            dev.tok_wr(i, 1, 1'b1);
            chk("hand back", 1, dev.owner[i]);
            run_op(OP_TOKEN_FREE, a, 32'h0);
            chk("freed", 0, dev.owner[i]);
        end
        $display("token test done");
        a = xs() & 32'h3fff;
        d = xs();
        run_op(OP_WRITE, a, d);
        reg_wr(REG_CONFIG, 32'h1);
        @(posedge core_clk);
        #1 chk("slave role", 0, role_master);
        busy_n <= 1'b0;
        start_op(OP_WRITE, a, ~d);
        repeat (10) @(posedge core_clk);
        reg_wr(REG_ADDR, a ^ 32'h1);
        reg_rd(REG_ADDR, s);
        chk("addr refused", a, s);
        reg_rd(REG_STATUS, s);
        chk("waiting", 1, s[ST_WAIT_BIT]);
        chk("held off", exp_word(d), dev.mem[a[14:0]]);
        busy_n <= 1'b1;
        wait_done(s);
        chk("slave write", exp_word(~d), dev.mem[a[14:0]]);
        reg_wr(REG_CONFIG, 32'h0);
        $display("slave test done");
        finish_test();
    end
endmodule
`default_nettype wire
